// *** logic/vifc_top.sv ***
// VBI filter combine, interrupt A and configuration RAM port
`timescale 1ns/10ps
module vifc_top
    import vifc_pkg::*;
#(
    parameter int SETS      = RAM_SETS,
    parameter int SET_BYTES = RAM_SET_BYTES
) (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic [vifc_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [vifc_pkg::DATA_W-1:0]   reg_wdata,
    output logic      [vifc_pkg::DATA_W-1:0]   reg_rdata,
    output logic                               reg_rvalid,
    input  wire logic                          video_lock,
    input  wire logic [7:0]                    fifo_word_count,
    input  wire logic                          line_reached,
    input  wire logic                          data_available,
    input  wire logic [vifc_pkg::FILT_W-1:0]   teletext_table,
    input  wire logic [7:0]                    teletext_byte,
    input  wire logic                          teletext_byte_valid,
    input  wire logic                          teletext_pkt_start,
    output logic                               teletext_pass,
    output logic                               teletext_pass_valid,
    output logic                               int_pin_o,
    output logic                               int_pin_oe_n,
    output logic                               pixel_output_enable
);
    import vifc_pkg::*;

    if (SETS * SET_BYTES != (1 << RAM_AW)) begin
        $error("RAM geometry does not match address width");
    end
    if (SETS < STD_SETS + CUSTOM_SETS) begin
        $error("Too few RAM sets for standard and custom use");
    end

    vifc_ram_if #(.AW(RAM_AW), .DW(DATA_W)) ram_bus ();

    logic [7:0]        filt_ctrl_q;
    logic [7:0]        int_stat_q;
    logic [7:0]        int_en_q;
    logic [7:0]        int_cfg_q;
    logic [7:0]        fifo_thr_q;
    logic [RAM_AW-1:0] ram_ptr_q;
    logic              lock_meta_q;
    logic              lock_sync_q;
    logic              lock_prev_q;
    logic              above_prev_q;
    logic              int_active_q;
    logic              rd_pend_q;
    logic              rd_ram_q;
    logic [7:0]        rd_addr_q;
    logic [2:0]        byte_idx_q;
    logic              pkt_busy_q;
    logic [1:0]        match_q;

    logic              wr_stat;
    logic              above_thr;
    logic [7:0]        stat_set;
    logic              ram_access;
    logic [2:0]        prefix_len;
    logic [2:0]        idx_eff;
    logic [3:0]        teletext_nibble;
    logic [1:0]        match_d;
    logic              byte_take;
    logic              last_byte;
    logic [1:0]        filt_res;
    logic              pass_d;

    // Register writes
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            filt_ctrl_q <= RST_FILT_CTRL;
            int_en_q    <= RST_INT_EN;
            int_cfg_q   <= RST_INT_CFG;
            fifo_thr_q  <= RST_FIFO_THR;
        end else if (reg_wr) begin
            case (reg_addr)
                OFS_FILT_CTRL: filt_ctrl_q <= reg_wdata & FC_MASK;
                OFS_INT_EN:    int_en_q    <= reg_wdata & EN_MASK;
                OFS_INT_CFG: begin
                    int_cfg_q[CF_POL]   <= reg_wdata[CF_POL];
                    int_cfg_q[CF_PIXOE] <= reg_wdata[CF_PIXOE];
                end
                OFS_FIFO_THR:  fifo_thr_q  <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // Lock input synchroniser and edge history
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_meta_q  <= 1'b0;
            lock_sync_q  <= 1'b0;
            lock_prev_q  <= 1'b0;
            above_prev_q <= 1'b0;
        end else begin
            lock_meta_q  <= video_lock;
            lock_sync_q  <= lock_meta_q;
            lock_prev_q  <= lock_sync_q;
            above_prev_q <= above_thr;
        end
    end

    assign above_thr = fifo_word_count > fifo_thr_q;
    assign wr_stat   = reg_wr && (reg_addr == OFS_INT_STAT);

    // Event sources, independent of the enables
    always_comb begin
        stat_set = 8'h00;
        stat_set[ST_LOCKCH] = lock_sync_q ^ lock_prev_q;
        stat_set[ST_THR]    = above_thr & ~above_prev_q;
        stat_set[ST_LINE]   = line_reached;
        stat_set[ST_DATA]   = data_available;
    end

    // Sticky status, set wins over a write-one clear
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_stat_q <= RST_INT_STAT;
        end else begin
            int_stat_q[ST_LOCK] <= lock_sync_q;
            int_stat_q[6:0] <= ((int_stat_q[6:0]
                & ~(wr_stat ? reg_wdata[6:0] : 7'h00))
                | stat_set[6:0]) & ST_STICKY[6:0];
        end
    end

    // Interrupt pin drive
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_active_q <= 1'b0;
            int_pin_o    <= 1'b0;
            int_pin_oe_n <= 1'b1;
        end else begin
            int_active_q <= |(int_stat_q & int_en_q);
            if (int_cfg_q[CF_POL]) begin
                int_pin_o    <= |(int_stat_q & int_en_q);
                int_pin_oe_n <= 1'b0;
            end else begin
                int_pin_o    <= 1'b0;
                int_pin_oe_n <= ~|(int_stat_q & int_en_q);
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pixel_output_enable <= 1'b1;
        end else begin
            pixel_output_enable <= int_cfg_q[CF_PIXOE];
        end
    end

    // Configuration RAM pointer
    assign ram_access = (reg_wr || reg_rd) && (reg_addr == OFS_RAM_DATA);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ram_ptr_q <= '0;
        end else if (reg_wr && reg_addr == OFS_RAM_ADDR_L) begin
            ram_ptr_q[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == OFS_RAM_ADDR_H) begin
            ram_ptr_q[RAM_AW-1] <= reg_wdata[0];
        end else if (ram_access) begin
            ram_ptr_q <= ram_ptr_q + 1'b1;
        end
    end

    assign ram_bus.we    = reg_wr && (reg_addr == OFS_RAM_DATA);
    assign ram_bus.re    = reg_rd && (reg_addr == OFS_RAM_DATA);
    assign ram_bus.addr  = ram_ptr_q;
    assign ram_bus.wdata = reg_wdata;

    vifc_cfg_ram #(
        .DEPTH (SETS * SET_BYTES),
        .AW    (RAM_AW),
        .DW    (DATA_W)
    ) u_ram (
        .ref_clk (ref_clk),
        .port    (ram_bus.mem)
    );

    // Register read, answer two edges after the strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_pend_q  <= 1'b0;
            rd_ram_q   <= 1'b0;
            rd_addr_q  <= 8'h00;
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            rd_pend_q  <= reg_rd;
            rd_ram_q   <= ram_bus.re;
            rd_addr_q  <= reg_addr;
            reg_rvalid <= rd_pend_q;
            if (rd_pend_q) begin
                case (rd_addr_q)
                    OFS_FILT_CTRL:  reg_rdata <= filt_ctrl_q;
                    OFS_INT_STAT:   reg_rdata <= int_stat_q;
                    OFS_INT_EN:     reg_rdata <= int_en_q;
                    OFS_INT_CFG:    reg_rdata <= {5'h00,
                        int_cfg_q[CF_PIXOE], int_active_q,
                        int_cfg_q[CF_POL]};
                    OFS_RAM_DATA:   reg_rdata <= rd_ram_q ?
                        ram_bus.rdata : 8'h00;
                    OFS_RAM_ADDR_L: reg_rdata <= ram_ptr_q[7:0];
                    OFS_RAM_ADDR_H: reg_rdata <= {7'h00,
                        ram_ptr_q[RAM_AW-1]};
                    OFS_FIFO_THR:   reg_rdata <= fifo_thr_q;
                    default:        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Teletext prefix filters
    assign prefix_len = filt_ctrl_q[FC_MODE] ? 3'(PREFIX_LONG)
                                             : 3'(PREFIX_SHORT);
    assign teletext_nibble = {teletext_byte[7], teletext_byte[5],
                              teletext_byte[3], teletext_byte[1]};
    assign byte_take  = teletext_byte_valid
                        && (teletext_pkt_start || pkt_busy_q);
    assign idx_eff    = teletext_pkt_start ? 3'd0 : byte_idx_q;
    assign last_byte  = idx_eff == prefix_len - 3'd1;

    always_comb begin
        match_d = 2'b00;
        for (int f = 0; f < 2; f++) begin
            logic [7:0] ent;
            ent = teletext_table[(f * FILT_BYTES + int'(idx_eff)) * 8 +: 8];
            match_d[f] = (teletext_pkt_start | match_q[f])
                & (((teletext_nibble ^ ent[3:0]) & ent[7:4]) == 4'h0);
        end
    end

    assign filt_res = match_d & {filt_ctrl_q[FC_EN2], filt_ctrl_q[FC_EN1]};

    always_comb begin
        case (vifc_logic_t'(filt_ctrl_q[FC_LOGIC +: 2]))
            VIFC_NOR:  pass_d = ~(filt_res[0] | filt_res[1]);
            VIFC_NAND: pass_d = ~(filt_res[0] & filt_res[1]);
            VIFC_OR:   pass_d = filt_res[0] | filt_res[1];
            VIFC_AND:  pass_d = filt_res[0] & filt_res[1];
            default:   pass_d = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_idx_q     <= 3'd0;
            pkt_busy_q     <= 1'b0;
            match_q        <= 2'b00;
            teletext_pass       <= 1'b0;
            teletext_pass_valid <= 1'b0;
        end else begin
            teletext_pass_valid <= 1'b0;
            if (byte_take) begin
                match_q    <= match_d;
                byte_idx_q <= idx_eff + 3'd1;
                pkt_busy_q <= ~last_byte;
                if (last_byte) begin
                    teletext_pass       <= pass_d;
                    teletext_pass_valid <= 1'b1;
                end
            end
        end
    end
endmodule

// *** logic/vifc_pkg.sv ***
// Constants and types for the VBI interrupt and filter control block
// How it works
// - Two-bit field merges filters: NOR/NAND/OR/AND
// - Mode bit picks two or five prefix bytes
// - Per-filter enables; zero mask always matches
// - Status bits 6, 2, 1, 0 stick until host writes one
// - Lock change in either direction sets bit 6
// - Bit 7 shows current video lock state
// - FIFO level crossing threshold sets bit 2
// - Reaching programmed line sets bit 1
// - Sliced data available sets bit 0
// - Enables gate only the pin, not status
// - Pin active on enabled status; bit mirrors it
// - Polarity: open-drain low or push-pull high
// - Config bit 2 gates pixel outputs, reset 04h
// - Config RAM 512 bytes, 32 sets of 16
// - Data port access uses counter then increments
// - Address registers load nine-bit start address
// - Twelve standard sets plus two custom sets
// - Word count above threshold, reset 80h, triggers
package vifc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_FILT_CTRL  = 8'hBB;
    localparam logic [7:0] OFS_INT_STAT   = 8'hC0;
    localparam logic [7:0] OFS_INT_EN     = 8'hC1;
    localparam logic [7:0] OFS_INT_CFG    = 8'hC2;
    localparam logic [7:0] OFS_RAM_DATA   = 8'hC3;
    localparam logic [7:0] OFS_RAM_ADDR_L = 8'hC4;
    localparam logic [7:0] OFS_RAM_ADDR_H = 8'hC5;
    localparam logic [7:0] OFS_FIFO_THR   = 8'hC8;

    localparam logic [7:0] RST_FILT_CTRL = 8'h00;
    localparam logic [7:0] RST_INT_STAT  = 8'h00;
    localparam logic [7:0] RST_INT_EN    = 8'h00;
    localparam logic [7:0] RST_INT_CFG   = 8'h04;
    localparam logic [7:0] RST_FIFO_THR  = 8'h80;

    // Filter control fields
    localparam int FC_EN1    = 0;
    localparam int FC_EN2    = 1;
    localparam int FC_MODE   = 2;
    localparam int FC_LOGIC  = 3;
    localparam logic [7:0] FC_MASK = 8'h1F;

    // Status and enable fields
    localparam int ST_DATA   = 0;
    localparam int ST_LINE   = 1;
    localparam int ST_THR    = 2;
    localparam int ST_LOCKCH = 6;
    localparam int ST_LOCK   = 7;
    localparam logic [7:0] ST_STICKY = 8'h47;
    localparam logic [7:0] EN_MASK   = 8'h47;

    // Configuration fields
    localparam int CF_POL    = 0;
    localparam int CF_ACTIVE = 1;
    localparam int CF_PIXOE  = 2;

    localparam int PREFIX_SHORT = 2;
    localparam int PREFIX_LONG  = 5;
    localparam int FILT_BYTES   = 5;
    localparam int FILT_W       = 2 * FILT_BYTES * 8;

    localparam int RAM_SETS      = 32;
    localparam int RAM_SET_BYTES = 16;
    localparam int RAM_AW        = 9;
    localparam int STD_SETS      = 12;
    localparam int CUSTOM_SETS   = 2;

    typedef enum logic [1:0] {
        VIFC_NOR,
        VIFC_NAND,
        VIFC_OR,
        VIFC_AND
    } vifc_logic_t;
endpackage

// *** logic/vifc_ram_if.sv ***
// Port between controller and configuration RAM
`timescale 1ns/10ps
interface vifc_ram_if #(parameter int AW = 9, parameter int DW = 8);
    logic          we;
    logic          re;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output re, output addr, output wdata,
                  input rdata);
    modport mem  (input we, input re, input addr, input wdata,
                  output rdata);
endinterface

// *** logic/vifc_cfg_ram.sv ***
// Slicer configuration RAM with registered read data
`timescale 1ns/10ps
module vifc_cfg_ram #(
    parameter int DEPTH = 512,
    parameter int AW    = 9,
    parameter int DW    = 8
) (
    input wire logic ref_clk,
    vifc_ram_if.mem  port
);
    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] rdata_q;

    if (DEPTH > (1 << AW)) begin
        $error("RAM depth exceeds address range");
    end

    // Memory array
    always_ff @(posedge ref_clk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
    end

    // Read port
    always_ff @(posedge ref_clk) begin
        if (port.re) begin
            rdata_q <= mem_q[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule

// *** testbench/vifc_monitor.sv ***
// Port checker for the VBI interrupt and filter control block
`timescale 1ns/10ps
module vifc_monitor
    import vifc_pkg::*;
#(
    parameter int SETS      = RAM_SETS,
    parameter int SET_BYTES = RAM_SET_BYTES
) (
    input wire logic                        ref_clk,
    input wire logic                        sys_rst,
    input wire logic [vifc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [vifc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [vifc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                        reg_rvalid,
    input wire logic                        line_reached,
    input wire logic                        teletext_byte_valid,
    input wire logic                        teletext_pkt_start,
    input wire logic                        teletext_pass,
    input wire logic                        teletext_pass_valid,
    input wire logic                        int_pin_o,
    input wire logic                        int_pin_oe_n,
    input wire logic                        pixel_output_enable
);
    logic       pol_q;
    logic       mode_q;
    logic [7:0] en_q;
    logic       unmapped;
    assign unmapped = !(reg_addr inside {OFS_FILT_CTRL, OFS_FIFO_THR,
                        [OFS_INT_STAT:OFS_RAM_ADDR_H]});
    // Mirrors of host-written control bits
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pol_q  <= 1'b0;
            mode_q <= 1'b0;
            en_q   <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == OFS_INT_CFG) pol_q <= reg_wdata[CF_POL];
            if (reg_addr == OFS_FILT_CTRL) mode_q <= reg_wdata[FC_MODE];
            if (reg_addr == OFS_INT_EN) en_q <= reg_wdata & EN_MASK;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    unmapped_zero_a: assert property (
        reg_rd && unmapped |-> ##2 reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    line_pin_a: assert property (
        line_reached && en_q[ST_LINE] |->
        ##2 !int_pin_oe_n && int_pin_o == pol_q)
        else $error("pin not active after line event");
    open_drain_a: assert property (
        (!pol_q [*2]) ##0 !int_pin_oe_n |-> !int_pin_o)
        else $error("open drain pin driven high");
    push_pull_a: assert property (
        pol_q [*2] |-> !int_pin_oe_n)
        else $error("push pull pin released");
    quiet_pin_a: assert property (
        (en_q == 8'h00 && !pol_q) [*3] |-> int_pin_oe_n)
        else $error("pin active with all sources masked");
    pixel_gate_a: assert property (
        reg_wr && reg_addr == OFS_INT_CFG |->
        ##2 pixel_output_enable == $past(reg_wdata[CF_PIXOE], 2))
        else $error("pixel enable not following config");
    pass_hold_a: assert property (
        !teletext_pass_valid |-> $stable(teletext_pass))
        else $error("filter result moved without strobe");
    short_prefix_a: assert property (
        !mode_q && teletext_byte_valid && teletext_pkt_start
        ##1 teletext_byte_valid && !teletext_pkt_start
        |=> teletext_pass_valid)
        else $error("two byte prefix result missing");
    long_prefix_a: assert property (
        mode_q && teletext_byte_valid && teletext_pkt_start
        |=> !teletext_pass_valid [*3])
        else $error("five byte prefix result too early");
    read_answer_a: assert property (
        reg_rd && reg_addr == OFS_RAM_DATA |-> ##2 reg_rvalid)
        else $error("ram port read not answered");
endmodule
bind vifc_top vifc_monitor #(.SETS(SETS), .SET_BYTES(SET_BYTES)) i_mon (
    .ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rvalid, .line_reached, .teletext_byte_valid,
    .teletext_pkt_start, .teletext_pass, .teletext_pass_valid, .int_pin_o,
    .int_pin_oe_n, .pixel_output_enable);

// *** testbench/vifc_host_model.sv ***
// Host model driving the register port of the control block
`timescale 1ns/10ps
module vifc_host_model
    import vifc_pkg::*;
(
    input  wire logic                        ref_clk,
    output logic      [vifc_pkg::ADDR_W-1:0] reg_addr,
    output logic                             reg_wr,
    output logic                             reg_rd,
    output logic      [vifc_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic [vifc_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                        reg_rvalid
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // Idle bus shows inverted last value
    task automatic idle();
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic got;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        idle();
        got = 1'b0;
        d   = 8'hXX;
        for (int i = 0; i < 4 && !got; i++) begin
            @(negedge ref_clk);
            got = (reg_rvalid === 1'b1);
            if (got) d = reg_rdata;
        end
    endtask
    // Line modes all off before touching the RAM
    task automatic prep_ram();
        for (int a = 8'hD0; a <= 8'hFB; a++) wr(a[7:0], 8'hFF);
        wr(8'hCF, 8'h00);
    endtask
    // Both interrupt polarity copies kept equal
    task automatic set_pol(input logic p, input logic pix);
        wr(OFS_INT_CFG, {5'h00, pix, 1'b0, p});
        wr(8'h1E, {7'h00, p});
    endtask
endmodule

// *** testbench/tb_vbi_interrupt_filter_ctrl.sv ***
// Self-checking bench for the VBI interrupt and filter control block
`timescale 1ns/10ps
module tb_vbi_interrupt_filter_ctrl;
    import vifc_pkg::*;
    logic              ref_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata, v;
    logic              reg_wr, reg_rd, reg_rvalid;
    logic              video_lock = 1'b0;
    logic              line_reached = 1'b0;
    logic              data_available = 1'b0;
    logic [7:0]        fifo_word_count = 8'h00;
    logic [FILT_W-1:0] teletext_table = '0;
    logic [7:0]        teletext_byte = 8'h00;
    logic              teletext_byte_valid = 1'b0;
    logic              teletext_pkt_start = 1'b0;
    logic              teletext_pass, teletext_pass_valid;
    logic              int_pin_o, int_pin_oe_n;
    logic              pixel_output_enable;
    logic [15:0]       rst_tab [6] = '{16'hBB00, 16'hC000, 16'hC100,
                                       16'hC204, 16'hC880, 16'h1000};
    logic [7:0]        comb_tab = 8'h2D;
    int                errors = 0;
    int                n_compared = 0;

    always #12.5 ref_clk = ~ref_clk;

    vifc_top i_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid, .video_lock, .fifo_word_count,
        .line_reached, .data_available, .teletext_table, .teletext_byte,
        .teletext_byte_valid, .teletext_pkt_start, .teletext_pass,
        .teletext_pass_valid, .int_pin_o, .int_pin_oe_n,
        .pixel_output_enable);
    vifc_host_model i_host (.ref_clk, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_rvalid);

    task automatic final_report();
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, v);
        chk($sformatf("register %h", a), v, exp);
    endtask
    task automatic ev(input logic [1:0] k);
        @(posedge ref_clk);
        {data_available, line_reached} <= k;
        @(posedge ref_clk);
        {data_available, line_reached} <= 2'b00;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic pin(input logic [7:0] exp);
        chk("interrupt pin", {6'h00, int_pin_oe_n, int_pin_o}, exp);
    endtask
    task automatic pkt(input int n, input logic [7:0] b0, input logic [7:0] b4,
                       input logic exp);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            teletext_byte       <= (i == 0) ? b0 : (i == 4) ? b4 : 8'h00;
            teletext_byte_valid <= 1'b1;
            teletext_pkt_start  <= (i == 0);
        end
        @(posedge ref_clk);
        teletext_byte_valid <= 1'b0;
        teletext_pkt_start  <= 1'b0;
        @(negedge ref_clk);
        chk("filter strobe", {7'h00, teletext_pass_valid}, 8'h01);
        chk("filter result", {7'h00, teletext_pass}, {7'h00, exp});
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        final_report();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (rst_tab[i]) rchk(rst_tab[i][15:8], rst_tab[i][7:0]);
        chk("pixel enable", {7'h00, pixel_output_enable}, 8'h01);
        pin(8'h02);
        ev(2'b11);
        rchk(OFS_INT_STAT, 8'h03);
        pin(8'h02);
        i_host.wr(OFS_INT_STAT, 8'h00);
        rchk(OFS_INT_STAT, 8'h03);
        i_host.wr(OFS_INT_STAT, 8'h02);
        rchk(OFS_INT_STAT, 8'h01);
        i_host.wr(OFS_INT_STAT, 8'hFF);
        rchk(OFS_INT_STAT, 8'h00);
        @(posedge ref_clk);
        video_lock <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rchk(OFS_INT_STAT, 8'hC0);
        i_host.wr(OFS_INT_STAT, 8'hC0);
        rchk(OFS_INT_STAT, 8'h80);
        @(posedge ref_clk);
        video_lock <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rchk(OFS_INT_STAT, 8'h40);
        i_host.wr(OFS_INT_STAT, 8'h40);
        i_host.wr(OFS_FIFO_THR, 8'h10);
        fifo_word_count <= 8'h10;
        rchk(OFS_INT_STAT, 8'h00);
        @(posedge ref_clk);
        fifo_word_count <= 8'h11;
        rchk(OFS_INT_STAT, 8'h04);
        i_host.wr(OFS_INT_STAT, 8'h04);
        i_host.wr(OFS_INT_EN, 8'hFF);
        rchk(OFS_INT_EN, 8'h47);
        i_host.wr(OFS_INT_EN, 8'h02);
        ev(2'b01);
        rchk(OFS_INT_CFG, 8'h06);
        pin(8'h00);
        i_host.wr(OFS_INT_STAT, 8'h02);
        rchk(OFS_INT_CFG, 8'h04);
        pin(8'h02);
        i_host.set_pol(1'b1, 1'b1);
        rchk(OFS_INT_CFG, 8'h05);
        pin(8'h00);
        ev(2'b01);
        rchk(OFS_INT_CFG, 8'h07);
        pin(8'h01);
        i_host.wr(OFS_INT_STAT, 8'h02);
        i_host.set_pol(1'b0, 1'b0);
        rchk(OFS_INT_CFG, 8'h00);
        chk("pixel enable", {7'h00, pixel_output_enable}, 8'h00);
        i_host.set_pol(1'b0, 1'b1);
        i_host.prep_ram();
        i_host.wr(OFS_RAM_ADDR_H, 8'h01);
        i_host.wr(OFS_RAM_ADDR_L, 8'hFE);
        for (int i = 0; i < 4; i++) i_host.wr(OFS_RAM_DATA, 8'hA0 + i[7:0]);
        rchk(OFS_RAM_ADDR_L, 8'h02);
        rchk(OFS_RAM_ADDR_H, 8'h00);
        i_host.wr(OFS_RAM_ADDR_H, 8'h01);
        i_host.wr(OFS_RAM_ADDR_L, 8'hFE);
        for (int i = 0; i < 4; i++) rchk(OFS_RAM_DATA, 8'hA0 + i[7:0]);
        @(posedge ref_clk);
        teletext_table <= {40'h0, 8'hFA, 24'h0, 8'hF5};
        for (int k = 0; k < 8; k++) begin
            i_host.wr(OFS_FILT_CTRL, {3'h0, k[2:1], 3'h1});
            pkt(2, k[0] ? 8'h22 : 8'h00, 8'h00, comb_tab[k]);
        end
        i_host.wr(OFS_FILT_CTRL, 8'h1F);
        pkt(5, 8'h22, 8'h88, 1'b1);
        pkt(5, 8'h22, 8'h00, 1'b0);
        i_host.wr(OFS_FILT_CTRL, 8'h1B);
        pkt(2, 8'h22, 8'h00, 1'b1);
        final_report();
    end
endmodule
